/* hw/pmbc_pkg.sv */
// Constants shared by the processor mode and external bus controller
package pmbc_pkg;
    localparam int ADDR_W = 20;
    localparam int REG_W = 8;
    // Mode-select field encodings
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXPAND = 2'h1;
    localparam logic [1:0] MODE_FORBID = 2'h2;
    localparam logic [1:0] MODE_MICRO = 2'h3;
    // Bus-mode field encodings
    localparam logic [1:0] BUS_SEPARATE = 2'h0;
    localparam logic [1:0] BUS_MUX_CS2 = 2'h1;
    localparam logic [1:0] BUS_MUX_CS1 = 2'h2;
    localparam logic [1:0] BUS_MUX_ALL = 2'h3;
    // Register A field positions
    localparam int A_MODE_LO = 0;
    localparam int A_BUSMUX_LO = 4;
    localparam int A_TOP_PORT = 6;
    localparam logic [7:0] A_UPPER_MASK = 8'hfc;
    // Register B field positions
    localparam int B_INT_RSV = 0;
    localparam int B_MID_PORT = 1;
    localparam int B_SET_ONLY = 2;
    localparam int B_EXT_AREA = 3;
    localparam int B_GWAIT = 7;
    localparam logic [7:0] RESET_A = 8'h00;
    localparam logic [7:0] RESET_B = 8'h00;
    // Memory map
    localparam logic [19:0] SFR_HI = 20'h003ff;
    localparam logic [19:0] RAM_LO = 20'h00400;
    localparam logic [19:0] RAM_LIM_HI = 20'h03fff;
    localparam logic [19:0] ROM_LIM_LO = 20'hd0000;
    localparam logic [19:0] EXT_A_LO = 20'h04000;
    localparam logic [19:0] EXT_A_HI = 20'h07fff;
    localparam logic [19:0] EXT_B_LO = 20'h80000;
    localparam logic [19:0] EXT_B_HI = 20'hcffff;
    // Chip-select areas, index 0 to 3
    localparam logic [3:0][19:0] CS_LO = {20'h04000, 20'h08000, 20'h28000, 20'h30000};
    localparam logic [3:0][19:0] CS_HI = {20'h07fff, 20'h27fff, 20'h2ffff, 20'hfffff};
    localparam logic [1:0] CS_IDX_MUX1 = 2'h1;
    localparam logic [1:0] CS_IDX_MUX2 = 2'h2;
    localparam logic [19:0] MUX_AREA_SPAN = 20'h00100;
    // Address pin masks
    localparam logic [19:0] MASK_12 = 20'h00fff;
    localparam logic [19:0] MASK_16 = 20'h0ffff;
    localparam logic [19:0] MASK_20 = 20'hfffff;
    localparam logic [19:0] MASK_FULLMUX = 20'h001ff;
    localparam logic [3:0] CS_ALL_OFF = 4'hf;
    typedef enum logic [1:0] {
        PMBC_ST_CAPTURE = 2'b01,
        PMBC_ST_RUN = 2'b10
    } pmbc_state_e;
endpackage

/* hw/pmbc_area_decode.sv */
// Address decoder: internal memories, reserved ranges and chip-select areas
`timescale 1ns/10ps
module pmbc_area_decode #(
    parameter logic [19:0] RAM_FULL_HI = 20'h07fff,
    parameter logic [19:0] ROM_FULL_LO = 20'hc0000
) (
    input wire logic [pmbc_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] proc_mode,
    input wire logic ext_area_en,
    input wire logic rom_locked,
    output logic hit_sfr,
    output logic hit_ram,
    output logic hit_rom,
    output logic hit_ext,
    output logic hit_rsv,
    output logic [1:0] area_idx,
    output logic area_in_span
);
    import pmbc_pkg::*;

    logic [3:0] area_hit;
    logic [19:0] ram_hi;
    logic [19:0] rom_lo;
    logic ext_window;
    logic rom_region;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_area
            assign area_hit[gi] = (addr >= CS_LO[gi]) && (addr <= CS_HI[gi]);
        end
    endgenerate

    always_comb begin
        // Extended area widens both internal memories
        ram_hi = ext_area_en ? RAM_FULL_HI : RAM_LIM_HI;
        rom_lo = ext_area_en ? ROM_FULL_LO : ROM_LIM_LO;
        ext_window = ((addr >= EXT_A_LO) && (addr <= EXT_A_HI)) ||
                     ((addr >= EXT_B_LO) && (addr <= EXT_B_HI));
        rom_region = addr >= rom_lo;
        hit_sfr = addr <= SFR_HI;
        hit_ram = (addr >= RAM_LO) && (addr <= ram_hi);
        // Micro mode and a locked ROM both hand the ROM range to the bus
        hit_rom = rom_region && (proc_mode != MODE_MICRO) && !rom_locked;
        hit_rsv = ext_area_en && ext_window && !hit_ram && !rom_region;
        hit_ext = !hit_sfr && !hit_ram && !hit_rom && !hit_rsv;
        area_idx = 2'h0;
        if (area_hit[3]) begin
            area_idx = 2'h3;
        end else if (area_hit[2]) begin
            area_idx = 2'h2;
        end else if (area_hit[1]) begin
            area_idx = 2'h1;
        end
        area_in_span = (addr - CS_LO[area_idx]) < MUX_AREA_SPAN;
    end
endmodule

/* hw/pmbc_ctrl.sv */
// Processor mode registers and external bus control
//
// Behaviour
// - Reset strap picks single-chip or microprocessor mode.
// - Mode codes 00, 01, 11; 10 forbidden.
// - Writing mode field switches mode regardless of strap.
// - Strap-high reset locks internal ROM out; the flash variant also needs the flash mode strap high.
// - Full multiplexing in expansion mode frees port pins, 256-byte areas.
// - Mode field survives software and watchdog reset.
// - Register B writes need protect release.
// - Rewrite flag forces reserved and extended bits.
// - Set-only bit ignores written zeros.
// - Global and per-area wait states.
// - Extended-area bit moves internal/external boundaries.
// - Multiplexed data shares A0 or A1 pins.
// - Multiplexed space reachable at even addresses.
// - Address width 12, 16 or 20 bits.
// - Address indeterminate until first external access.
// - Bus width follows strap, 8 or 16.
// - Chip-select pins are ports or active-low selects.
// - Address and select change by access kind.
// - Bus-mode field selects separate or multiplexed.
// - Bus-mode codes: separate, CS2, CS1, all.
`timescale 1ns/10ps
module pmbc_ctrl #(
    parameter bit FLASH_VARIANT = 1'b1,
    parameter logic [19:0] RAM_FULL_HI = 20'h07fff,
    parameter logic [19:0] ROM_FULL_LO = 20'hc0000
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic mode_strap_pin,
    input wire logic flash_mode_strap,
    input wire logic bus_width_strap,
    input wire logic soft_reset,
    input wire logic wdt_reset,
    input wire logic protect_release_bit,
    input wire logic cpu_rewrite_flag,
    input wire logic reg_a_wr,
    input wire logic reg_b_wr,
    input wire logic [pmbc_pkg::REG_W-1:0] wr_data,
    input wire logic [3:0] cs_enable,
    input wire logic [3:0] area_wait_select,
    input wire logic acc_valid,
    input wire logic [pmbc_pkg::ADDR_W-1:0] acc_addr,
    output logic [pmbc_pkg::REG_W-1:0] processor_mode_reg_a,
    output logic [pmbc_pkg::REG_W-1:0] processor_mode_reg_b,
    output logic [1:0] proc_mode,
    output logic rom_locked,
    output logic data_width_16,
    output logic [pmbc_pkg::ADDR_W-1:0] addr_pin_en,
    output logic [pmbc_pkg::ADDR_W-1:0] ext_addr,
    output logic addr_known,
    output logic [3:0] cs_n,
    output logic acc_int,
    output logic acc_ext,
    output logic acc_fault,
    output logic acc_wait,
    output logic acc_muxed,
    output logic data_lsb_on_a1,
    output logic data_hi_unused
);
    import pmbc_pkg::*;

    // Mode and configuration state
    pmbc_state_e state_q;
    pmbc_state_e state_d;
    logic [7:0] reg_a_q;
    logic [7:0] reg_a_d;
    logic [7:0] reg_b_q;
    logic [7:0] reg_b_d;
    logic rom_locked_q;
    logic rom_locked_d;

    // Bus state
    logic [19:0] ext_addr_q;
    logic [19:0] ext_addr_d;
    logic addr_known_q;
    logic addr_known_d;
    logic [3:0] cs_n_q;
    logic [3:0] cs_n_d;
    logic acc_int_q;
    logic acc_int_d;
    logic acc_ext_q;
    logic acc_ext_d;
    logic acc_fault_q;
    logic acc_fault_d;
    logic acc_wait_q;
    logic acc_wait_d;
    logic acc_muxed_q;
    logic acc_muxed_d;

    // Decoder results
    logic hit_sfr;
    logic hit_ram;
    logic hit_rom;
    logic hit_ext;
    logic hit_rsv;
    logic [1:0] area_idx;
    logic area_in_span;

    // Derived configuration
    logic [7:0] reg_b_eff;
    logic [1:0] mode_sel;
    logic [1:0] bus_mux;
    logic full_mux;
    logic area_muxed;
    logic [19:0] width_mask;
    logic [19:0] pin_mask;
    logic [7:0] wr_a;
    logic fault;
    logic ext_cycle;
    logic int_cycle;

    pmbc_area_decode #(
        .RAM_FULL_HI(RAM_FULL_HI),
        .ROM_FULL_LO(ROM_FULL_LO)
    ) u_decode (
        .addr(acc_addr),
        .proc_mode(mode_sel),
        .ext_area_en(reg_b_eff[B_EXT_AREA]),
        .rom_locked(rom_locked_q),
        .hit_sfr(hit_sfr),
        .hit_ram(hit_ram),
        .hit_rom(hit_rom),
        .hit_ext(hit_ext),
        .hit_rsv(hit_rsv),
        .area_idx(area_idx),
        .area_in_span(area_in_span)
    );

    // Configuration view seen by the rest of the block
    always_comb begin
        reg_b_eff = reg_b_q;
        if (cpu_rewrite_flag) begin
            reg_b_eff[B_INT_RSV] = 1'b1;
            reg_b_eff[B_EXT_AREA] = 1'b1;
        end
        mode_sel = reg_a_q[A_MODE_LO +: 2];
        bus_mux = (mode_sel == MODE_SINGLE) ? BUS_SEPARATE : reg_a_q[A_BUSMUX_LO +: 2];
        // All-space multiplexing shrinks areas only in expansion mode
        full_mux = (bus_mux == BUS_MUX_ALL) && (mode_sel == MODE_EXPAND);
        area_muxed = (bus_mux == BUS_MUX_ALL) ||
                     ((bus_mux == BUS_MUX_CS2) && (area_idx == CS_IDX_MUX2)) ||
                     ((bus_mux == BUS_MUX_CS1) && (area_idx == CS_IDX_MUX1));
        // The one illegal select pair falls back to the narrowest bus
        case ({reg_b_q[B_MID_PORT], reg_a_q[A_TOP_PORT]})
            2'b00: width_mask = MASK_20;
            2'b01: width_mask = MASK_16;
            default: width_mask = MASK_12;
        endcase
        pin_mask = full_mux ? (width_mask & MASK_FULLMUX) : width_mask;
    end

    // Access classification
    always_comb begin
        fault = hit_rsv;
        if (hit_ext && (mode_sel == MODE_SINGLE)) begin
            fault = 1'b1;
        end else if (hit_ext && area_muxed && acc_addr[0]) begin
            fault = 1'b1;
        end else if (hit_ext && full_mux && !area_in_span) begin
            fault = 1'b1;
        end
        ext_cycle = acc_valid && hit_ext && !fault;
        int_cycle = acc_valid && (hit_sfr || hit_ram || hit_rom) && !fault;
    end

    // Register and mode next-state
    always_comb begin
        state_d = state_q;
        reg_a_d = reg_a_q;
        reg_b_d = reg_b_q;
        rom_locked_d = rom_locked_q;
        wr_a = wr_data;
        case (state_q)
            PMBC_ST_CAPTURE: begin
                // Straps are sampled on the first enabled edge after release
                reg_a_d[A_MODE_LO +: 2] = mode_strap_pin ? MODE_MICRO : MODE_SINGLE;
                rom_locked_d = mode_strap_pin && (flash_mode_strap || !FLASH_VARIANT);
                state_d = PMBC_ST_RUN;
            end
            PMBC_ST_RUN: begin
                if (soft_reset || wdt_reset) begin
                    reg_a_d = (RESET_A & A_UPPER_MASK) | (reg_a_q & ~A_UPPER_MASK);
                    reg_b_d = RESET_B;
                end else begin
                    if (reg_a_wr) begin
                        // A forbidden mode code leaves the current mode in place
                        if (wr_data[A_MODE_LO +: 2] == MODE_FORBID) begin
                            wr_a[A_MODE_LO +: 2] = reg_a_q[A_MODE_LO +: 2];
                        end
                        reg_a_d = wr_a;
                    end
                    if (reg_b_wr && protect_release_bit) begin
                        reg_b_d = wr_data;
                        reg_b_d[B_SET_ONLY] = reg_b_q[B_SET_ONLY] | wr_data[B_SET_ONLY];
                    end
                end
            end
            default: begin
                state_d = PMBC_ST_CAPTURE;
            end
        endcase
    end

    // Bus cycle next-state
    // Address moves only on an accepted external cycle; an internal cycle turns all selects off, other cycles keep the pins quiet
    always_comb begin
        ext_addr_d = ext_addr_q;
        cs_n_d = cs_n_q;
        addr_known_d = addr_known_q;
        acc_int_d = int_cycle;
        acc_ext_d = ext_cycle;
        acc_fault_d = acc_valid && fault;
        acc_muxed_d = ext_cycle && area_muxed;
        // Global wait covers external and non-SFR internal; area bit 0 forces one
        acc_wait_d = (reg_b_eff[B_GWAIT] && ((int_cycle && !hit_sfr) || ext_cycle)) ||
                     (ext_cycle && (!area_wait_select[area_idx] || area_muxed));
        if (ext_cycle) begin
            ext_addr_d = acc_addr & pin_mask;
            cs_n_d = CS_ALL_OFF;
            cs_n_d[area_idx] = !cs_enable[area_idx];
            addr_known_d = 1'b1;
        end else if (int_cycle) begin
            cs_n_d = CS_ALL_OFF;
        end
        // Leaving single-chip mode, the pins hold stale data until used
        if ((mode_sel == MODE_SINGLE) && (reg_a_d[A_MODE_LO +: 2] != MODE_SINGLE)) begin
            addr_known_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PMBC_ST_CAPTURE;
            reg_a_q <= RESET_A;
            reg_b_q <= RESET_B;
            rom_locked_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            reg_a_q <= reg_a_d;
            reg_b_q <= reg_b_d;
            rom_locked_q <= rom_locked_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_addr_q <= '0;
            cs_n_q <= CS_ALL_OFF;
            addr_known_q <= 1'b0;
            acc_int_q <= 1'b0;
            acc_ext_q <= 1'b0;
            acc_fault_q <= 1'b0;
            acc_wait_q <= 1'b0;
            acc_muxed_q <= 1'b0;
        end else if (clk_en) begin
            ext_addr_q <= ext_addr_d;
            cs_n_q <= cs_n_d;
            addr_known_q <= addr_known_d;
            acc_int_q <= acc_int_d;
            acc_ext_q <= acc_ext_d;
            acc_fault_q <= acc_fault_d;
            acc_wait_q <= acc_wait_d;
            acc_muxed_q <= acc_muxed_d;
        end
    end

    // Register B shows the rewrite forcing without touching its stored bits
    assign processor_mode_reg_a = reg_a_q;
    assign processor_mode_reg_b = reg_b_eff;
    assign proc_mode = mode_sel;
    assign rom_locked = rom_locked_q;
    assign data_width_16 = !bus_width_strap;
    assign addr_pin_en = (mode_sel == MODE_SINGLE) ? '0 : pin_mask;
    assign ext_addr = ext_addr_q;
    assign addr_known = addr_known_q;
    assign cs_n = cs_n_q;
    assign acc_int = acc_int_q;
    assign acc_ext = acc_ext_q;
    assign acc_fault = acc_fault_q;
    assign acc_wait = acc_wait_q;
    assign acc_muxed = acc_muxed_q;
    // Wide bus shifts multiplexed data up one address pin
    assign data_lsb_on_a1 = !bus_width_strap;
    assign data_hi_unused = acc_muxed_q && !bus_width_strap;
endmodule

/* bench/pmbc_ctrl_monitor.sv */
// Concurrent checks on the mode and bus controller ports
`timescale 1ns/10ps
module pmbc_ctrl_monitor (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic soft_reset,
    input wire logic wdt_reset,
    input wire logic protect_release_bit,
    input wire logic cpu_rewrite_flag,
    input wire logic reg_a_wr,
    input wire logic acc_valid,
    input wire logic bus_width_strap,
    input wire logic [3:0] cs_enable,
    input wire logic [pmbc_pkg::REG_W-1:0] processor_mode_reg_b,
    input wire logic [1:0] proc_mode,
    input wire logic data_width_16,
    input wire logic data_lsb_on_a1,
    input wire logic [pmbc_pkg::ADDR_W-1:0] ext_addr,
    input wire logic addr_known,
    input wire logic [3:0] cs_n,
    input wire logic acc_int,
    input wire logic acc_ext,
    input wire logic acc_fault,
    input wire logic acc_muxed
);
    import pmbc_pkg::*;
    logic run_q;
    logic run_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // The strap capture edge is excluded: mode may legally change there
    always_comb begin
        run_d = run_q | clk_en;
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end
    sequence s_access;
        run_q && clk_en && acc_valid && !soft_reset && !wdt_reset;
    endsequence
    sequence s_b_locked;
        run_q && !protect_release_bit && !soft_reset && !wdt_reset && !cpu_rewrite_flag ##1 !cpu_rewrite_flag;
    endsequence
    a_access_answer: assert property (s_access |=> acc_int || acc_ext || acc_fault)
        else $error("access gave no result");
    a_fault_holds: assert property (acc_fault && !$past(soft_reset) && !$past(wdt_reset)
        |-> $stable(ext_addr) && $stable(cs_n))
        else $error("refused access moved the bus");
    a_int_deselect: assert property (acc_int && !$past(soft_reset) && !$past(wdt_reset)
        |-> cs_n == CS_ALL_OFF && $stable(ext_addr))
        else $error("internal access left select or moved address");
    a_idle_keeps: assert property (run_q && clk_en && !acc_valid && !reg_a_wr && !soft_reset && !wdt_reset
        |=> $stable(ext_addr) && $stable(cs_n))
        else $error("idle cycle changed the bus");
    a_ext_known: assert property (acc_ext |-> addr_known)
        else $error("external access with unknown address flag");
    a_mode_legal: assert property (proc_mode != MODE_FORBID)
        else $error("forbidden mode code held");
    a_mode_kept: assert property (run_q && (soft_reset || wdt_reset) |=> $stable(proc_mode))
        else $error("mode lost on software reset");
    a_set_sticky: assert property (run_q && processor_mode_reg_b[B_SET_ONLY] && !soft_reset && !wdt_reset
        |=> processor_mode_reg_b[B_SET_ONLY])
        else $error("set-only bit cleared");
    a_rewrite_force: assert property (cpu_rewrite_flag
        |-> processor_mode_reg_b[B_INT_RSV] && processor_mode_reg_b[B_EXT_AREA])
        else $error("rewrite flag did not force bits");
    a_b_protected: assert property (s_b_locked |-> $stable(processor_mode_reg_b))
        else $error("register B changed while protected");
    a_width_pins: assert property (data_width_16 == !bus_width_strap && data_lsb_on_a1 == !bus_width_strap)
        else $error("data width does not follow strap");
    a_cs_port_high: assert property (acc_ext |-> (~$past(cs_enable) & ~cs_n) == 4'h0)
        else $error("port pin driven as select");
    a_mux_even: assert property (acc_ext && acc_muxed |-> !ext_addr[0])
        else $error("odd multiplexed address");
endmodule

bind pmbc_ctrl pmbc_ctrl_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .soft_reset(soft_reset), .wdt_reset(wdt_reset), .protect_release_bit(protect_release_bit),
    .cpu_rewrite_flag(cpu_rewrite_flag), .reg_a_wr(reg_a_wr), .acc_valid(acc_valid),
    .bus_width_strap(bus_width_strap), .cs_enable(cs_enable), .processor_mode_reg_b(processor_mode_reg_b),
    .proc_mode(proc_mode), .data_width_16(data_width_16), .data_lsb_on_a1(data_lsb_on_a1),
    .ext_addr(ext_addr), .addr_known(addr_known), .cs_n(cs_n), .acc_int(acc_int), .acc_ext(acc_ext),
    .acc_fault(acc_fault), .acc_muxed(acc_muxed));

/* bench/pmbc_ext_dev.sv */
// External device model: reports which chip-select area answers a bus access
`timescale 1ns/10ps
module pmbc_ext_dev (
    input wire logic [3:0] cs_n,
    input wire logic [pmbc_pkg::ADDR_W-1:0] ext_addr,
    input wire logic acc_ext,
    input wire logic acc_muxed,
    output logic [2:0] sel_area,
    output logic odd_mux
);
    import pmbc_pkg::*;
    // Area 4 means no device selected
    always_comb begin
        sel_area = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (acc_ext && !cs_n[i]) begin
                sel_area = i[2:0];
            end
        end
        odd_mux = acc_ext && acc_muxed && ext_addr[0];
    end
endmodule

/* bench/pmbc_ctrl_bench.sv */
// Self-checking bench for the processor mode and external bus controller
`timescale 1ns/10ps
module pmbc_ctrl_bench;
    import pmbc_pkg::*;
    localparam logic [2:0] K_INT = 3'h4;
    localparam logic [2:0] K_EXT = 3'h2;
    localparam logic [2:0] K_FLT = 3'h1;
    logic ref_clk = 1'b0;
    logic nrst, clk_en, mode_strap_pin, flash_mode_strap, bus_width_strap, soft_reset, wdt_reset;
    logic protect_release_bit, cpu_rewrite_flag, reg_a_wr, reg_b_wr, acc_valid, odd_mux;
    logic [7:0] wr_data, reg_a, reg_b, m_a, m_b;
    logic [3:0] cs_enable, area_wait_select, cs_n;
    logic [19:0] acc_addr, addr_pin_en, ext_addr, ea;
    logic [1:0] proc_mode;
    logic [1:0] codes [4] = '{MODE_MICRO, MODE_FORBID, MODE_EXPAND, MODE_SINGLE};
    logic rom_locked, data_width_16, addr_known, acc_int, acc_ext, acc_fault, acc_wait, acc_muxed;
    logic data_lsb_on_a1, data_hi_unused;
    logic [2:0] sel_area;
    logic [15:0] lfsr = 16'hf515;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 ref_clk = ~ref_clk;
    pmbc_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .mode_strap_pin(mode_strap_pin),
        .flash_mode_strap(flash_mode_strap), .bus_width_strap(bus_width_strap), .soft_reset(soft_reset),
        .wdt_reset(wdt_reset), .protect_release_bit(protect_release_bit), .cpu_rewrite_flag(cpu_rewrite_flag),
        .reg_a_wr(reg_a_wr), .reg_b_wr(reg_b_wr), .wr_data(wr_data), .cs_enable(cs_enable),
        .area_wait_select(area_wait_select), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .processor_mode_reg_a(reg_a), .processor_mode_reg_b(reg_b), .proc_mode(proc_mode),
        .rom_locked(rom_locked), .data_width_16(data_width_16), .addr_pin_en(addr_pin_en),
        .ext_addr(ext_addr), .addr_known(addr_known), .cs_n(cs_n), .acc_int(acc_int), .acc_ext(acc_ext),
        .acc_fault(acc_fault), .acc_wait(acc_wait), .acc_muxed(acc_muxed), .data_lsb_on_a1(data_lsb_on_a1),
        .data_hi_unused(data_hi_unused));
    pmbc_ext_dev u_dev (.cs_n(cs_n), .ext_addr(ext_addr), .acc_ext(acc_ext), .acc_muxed(acc_muxed),
        .sel_area(sel_area), .odd_mux(odd_mux));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset(input logic strap, input logic width);
        nrst = 1'b0;
        mode_strap_pin = strap;
        flash_mode_strap = strap;
        bus_width_strap = width;
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (2) @(negedge ref_clk);
        m_a = {6'h00, strap, strap};
        m_b = 8'h00;
    endtask
    // Register write with the model updated alongside; bits with no field are masked
    task automatic wr(input logic b, input logic [7:0] d);
        acc_valid = 1'b0;
        reg_a_wr = !b;
        reg_b_wr = b;
        wr_data = d;
        @(negedge ref_clk);
        reg_a_wr = 1'b0;
        reg_b_wr = 1'b0;
        if (!b) begin
            m_a = (d[1:0] == MODE_FORBID) ? {d[7:2], m_a[1:0]} : d;
        end else if (protect_release_bit) begin
            m_b = d | (m_b & 8'h04);
        end
        chk(reg_a & 8'h73, m_a & 8'h73);
        chk(reg_b & 8'h8f, m_b & 8'h8f);
        chk(proc_mode, m_a[1:0]);
        // An edge passes so a following write never re-raises a strobe in the same step
        @(negedge ref_clk);
    endtask
    // Upper bits are written with a single-chip mode code first, then expansion mode is selected
    task automatic cfg_a(input logic [5:0] up);
        wr(1'b0, {up, MODE_SINGLE});
        wr(1'b0, {up, MODE_EXPAND});
    endtask
    task automatic acc(input logic [19:0] a, input logic [2:0] k);
        acc_valid = 1'b1;
        acc_addr = a;
        @(negedge ref_clk);
        chk({acc_int, acc_ext, acc_fault}, k);
    endtask
    task automatic idle();
        acc_valid = 1'b0;
        @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {nrst, soft_reset, wdt_reset, protect_release_bit, cpu_rewrite_flag} = 5'h00;
        {reg_a_wr, reg_b_wr, acc_valid} = 3'h0;
        clk_en = 1'b1;
        wr_data = 8'h00;
        acc_addr = 20'h00000;
        cs_enable = 4'hf;
        area_wait_select = 4'hf;
        do_reset(1'b1, 1'b1);
        chk(proc_mode, MODE_MICRO);
        chk(rom_locked, 1'b1);
        chk(data_width_16, 1'b0);
        wr(1'b0, 8'h01);
        chk(rom_locked, 1'b1);
        acc(20'hf0000, K_EXT);
        do_reset(1'b0, 1'b1);
        chk({rom_locked, proc_mode}, 3'h0);
        acc(20'h08010, K_FLT);
        acc(20'hf0000, K_INT);
        foreach (codes[i]) begin
            wr(1'b0, {m_a[7:2], codes[i]});
        end
        cfg_a(6'h00);
        chk(addr_known, 1'b0);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            ea = 20'h08000 + {3'h0, lfsr, 1'b0};
            acc(ea, K_EXT);
            chk({cs_n, ext_addr}, {4'hb, ea});
            chk({sel_area, addr_known}, 4'h5);
            acc(20'h00500, K_INT);
            chk({cs_n, ext_addr}, {CS_ALL_OFF, ea});
        end
        acc(20'h04010, K_EXT);
        chk({cs_n, ext_addr}, 24'h704010);
        idle();
        chk({cs_n, ext_addr}, 24'h704010);
        acc(20'h04020, K_EXT);
        chk({cs_n, ext_addr}, 24'h704020);
        acc(20'h80000, K_EXT);
        chk(cs_n, 4'he);
        cs_enable = 4'h7;
        acc(20'h04010, K_EXT);
        chk({cs_n, sel_area}, 7'h7c);
        cs_enable = 4'hf;
        area_wait_select = 4'hb;
        acc(20'h08010, K_EXT);
        chk(acc_wait, 1'b1);
        acc(20'h00500, K_INT);
        chk(acc_wait, 1'b0);
        wr(1'b1, 8'h80);
        protect_release_bit = 1'b1;
        wr(1'b1, 8'h80);
        acc(20'h00500, K_INT);
        chk(acc_wait, 1'b1);
        wr(1'b1, 8'h84);
        wr(1'b1, 8'h80);
        cpu_rewrite_flag = 1'b1;
        @(negedge ref_clk);
        chk(reg_b & 8'h8f, 8'h8d);
        cpu_rewrite_flag = 1'b0;
        wr(1'b1, 8'h08);
        acc(20'h80000, K_FLT);
        acc(20'h04000, K_INT);
        wr(1'b1, 8'h02);
        cfg_a(6'h10);
        acc(20'h08abc, K_EXT);
        chk(ext_addr, 20'h00abc);
        wr(1'b1, 8'h00);
        acc(20'h18abc, K_EXT);
        chk({addr_pin_en, ext_addr}, {MASK_16, 20'h08abc});
        area_wait_select = 4'h9;
        cfg_a(6'h04);
        acc(20'h08011, K_FLT);
        acc(20'h08012, K_EXT);
        chk({acc_muxed, acc_wait, odd_mux}, 3'h6);
        acc(20'h28010, K_EXT);
        chk(acc_muxed, 1'b0);
        cfg_a(6'h08);
        acc(20'h28010, K_EXT);
        chk(acc_muxed, 1'b1);
        cfg_a(6'h0c);
        acc(20'h08010, K_EXT);
        chk(ext_addr, 20'h00010);
        acc(20'h08200, K_FLT);
        for (int i = 0; i < 2; i++) begin
            wr(1'b1, 8'h84);
            soft_reset = (i == 0);
            wdt_reset = (i == 1);
            @(negedge ref_clk);
            {soft_reset, wdt_reset} = 2'h0;
            chk({proc_mode, reg_a & 8'h73, reg_b & 8'h8f}, {MODE_EXPAND, 8'h01, 8'h00});
            m_a = 8'h01;
            m_b = 8'h00;
        end
        do_reset(1'b0, 1'b0);
        chk({data_width_16, data_lsb_on_a1}, 2'h3);
        cfg_a(6'h04);
        acc(20'h08012, K_EXT);
        chk(data_hi_unused, 1'b1);
        // A low clock enable freezes the whole bus state
        clk_en = 1'b0;
        acc(20'h00500, K_EXT);
        chk({cs_n, ext_addr}, 24'hb08012);
        clk_en = 1'b1;
        idle();
        report_and_stop();
    end
endmodule
